// ==== alsp_defines.svh ====
`ifndef ALSP_DEFINES_SVH
`define ALSP_DEFINES_SVH

`define ALSP_CLK_NS 4
`define ALSP_STEP_NS 2730000
`define ALSP_PULSE_NS 16000
`define ALSP_PULSE_CYCLES (`ALSP_PULSE_NS / `ALSP_CLK_NS)
`define ALSP_LED_ON_CYCLES (`ALSP_PULSE_CYCLES / 2)
`define ALSP_LONG_WAIT_MULT 4'hc
`define ALSP_STEP_CAP 11'h400
`define ALSP_STEPS_FULL 9'h100
`define ALSP_COUNT_MAX 16'hffff

`define ALSP_ADDR_W 8
`define ALSP_OFF_ENABLE 8'h00
`define ALSP_OFF_TIME 8'h04
`define ALSP_OFF_ALS_THR 8'h08
`define ALSP_OFF_PROX_THR 8'h0c
`define ALSP_OFF_PERS 8'h10
`define ALSP_OFF_LED 8'h14
`define ALSP_OFF_STATUS 8'h18
`define ALSP_OFF_DATA 8'h1c
`define ALSP_OFF_PDATA 8'h20

`define ALSP_TIME_RST 32'h0000ffff
`define ALSP_THR_RST 32'hffff0000
`define ALSP_RESP_OKAY 2'h0
`define ALSP_RESP_DECERR 2'h3

`endif

// ==== alsp_pkg.sv ====
package alsp_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_PROX, ST_ALS, ST_WAIT, ST_SLEEP} alsp_state_e;

  typedef struct packed {
    logic [24:0] rsv;
    logic sleep_after_int;
    logic prox_int_en;
    logic als_int_en;
    logic wait_en;
    logic prox_en;
    logic als_en;
    logic power_on;
  } alsp_enable_s;

  typedef struct packed {
    logic [14:0] rsv;
    logic wait_long;
    logic [7:0] wait_setting;
    logic [7:0] light_integration_setting;
  } alsp_time_s;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } alsp_thr_s;

  typedef struct packed {
    logic [23:0] rsv;
    logic [3:0] prox;
    logic [3:0] ambient_light_path;
  } alsp_pers_s;

  typedef struct packed {
    logic [12:0] rsv;
    logic [7:0] prox_offset;
    logic led_power_divide;
    logic [1:0] led_sink_drive;
    logic [7:0] pulses;
  } alsp_led_s;

  typedef struct packed {
    logic [26:0] rsv;
    logic prox_sat;
    logic prox_int;
    logic als_int;
    logic prox_valid;
    logic als_valid;
  } alsp_status_s;

  typedef struct packed {
    logic [15:0] infrared_channel;
    logic [15:0] wideband_channel;
  } alsp_data_s;

  typedef struct packed {
    alsp_enable_s en;
    alsp_time_s tm;
    alsp_thr_s als_thr;
    alsp_thr_s prox_thr;
    alsp_pers_s pers;
    alsp_led_s led;
  } alsp_cfg_s;

  typedef struct packed {
    alsp_state_e state;
    alsp_cfg_s cfg;
    alsp_status_s st;
    logic [2:0] clk_s;
    logic [1:0] wb_s;
    logic [1:0] ir_s;
    logic [1:0] sat_s;
    logic [23:0] timer;
    logic [8:0] steps;
    logic [7:0] pulses;
    logic [3:0] mult;
    logic [10:0] wb_step;
    logic [10:0] ir_step;
    logic [15:0] wb_acc;
    logic [15:0] ir_acc;
    logic [15:0] prox_acc;
    alsp_data_s data;
    logic [15:0] prox_data;
    logic [3:0] als_pers_cnt;
    logic [3:0] prox_pers_cnt;
    logic aw_ok;
    logic w_ok;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic int_oe;
    logic led_oe;
    logic [1:0] led_level;
    logic led_div;
  } alsp_regs_s;

endpackage : alsp_pkg

// ==== alsp_core.sv ====
// Behaviour
// RULE1 - Both channels convert together, 16-bit results
// RULE2 - Data registers load only at conversion end
// RULE3 - Interrupt holds until host clears it
// RULE4 - Result outside threshold window raises interrupt
// RULE5 - Persistence count sets consecutive misses needed
// RULE6 - Light and proximity thresholds, persistence independent
// RULE7 - Each interrupt source maskable at output
// RULE8 - Interrupt pin active low, open drain
// RULE9 - LED drive selects 15/30/60/120 mA
// RULE10 - Power divide bit cuts LED power eightfold
// RULE11 - One to 255 LED pulses per measurement
// RULE12 - Each LED pulse spans 16 us
// RULE13 - Programmable wait, 2.7 ms to over 8 s
// RULE14 - Optional sleep after an interrupt rises
// RULE15 - Proximity saturation sets a status bit
// RULE16 - Proximity offset subtracted for crosstalk
// RULE17 - Host serial interface up to 400 kbit/s
// RULE18 - Integration 1..256 steps, all ones one step
// RULE19 - Light count saturates, 1024 per step max
// RULE20 - In-window result restarts persistence count
// RULE21 - Cycle proximity, light, wait while enabled
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "alsp_defines.svh"

module alsp_core #(
  parameter int unsigned STEP_CYCLES = `ALSP_STEP_NS / `ALSP_CLK_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sense_clk,
  input wire logic wideband_channel,
  input wire logic infrared_channel,
  input wire logic prox_saturated,
  output logic int_n_o,
  output logic int_n_oe,
  output logic led_sink_o,
  output logic led_sink_oe,
  output logic [1:0] led_sink_drive,
  output logic led_power_divide
);

  alsp_pkg::alsp_regs_s r;
  alsp_pkg::alsp_regs_s n;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  function automatic logic outside(input logic [15:0] v, input alsp_pkg::alsp_thr_s t);
    return (v < t.lo) || (v > t.hi); // RULE4
  endfunction : outside

  function automatic logic [15:0] sat_add(input logic [15:0] acc, input logic [10:0] step);
    logic [16:0] s;
    s = {1'b0, acc} + {6'h00, step};
    return s[16] ? `ALSP_COUNT_MAX : s[15:0]; // RULE19
  endfunction : sat_add

  // Returns the fire flag above the new consecutive-miss count
  function automatic logic [4:0] pers_step(input logic miss, input logic [3:0] cnt,
                                           input logic [3:0] need);
    logic [3:0] c;
    c = 4'h0;
    if (miss) begin
      c = (cnt == 4'hf) ? cnt : cnt + 4'h1;
    end
    // A setting of zero fires on every miss
    return {miss && (c >= need), c}; // RULE5 RULE20
  endfunction : pers_step

  function automatic alsp_pkg::alsp_regs_s go(input alsp_pkg::alsp_regs_s s,
                                              input alsp_pkg::alsp_state_e st);
    alsp_pkg::alsp_regs_s o;
    o = s;
    o.state = st;
    o.timer = 24'(STEP_CYCLES - 1);
    o.wb_step = 11'h000;
    o.ir_step = 11'h000;
    o.wb_acc = 16'h0000;
    o.ir_acc = 16'h0000;
    o.prox_acc = 16'h0000;
    o.steps = `ALSP_STEPS_FULL - {1'b0, s.cfg.tm.light_integration_setting}; // RULE18
    o.mult = 4'h1;
    o.pulses = 8'h00;
    if (st == alsp_pkg::ST_PROX) begin
      o.timer = 24'(`ALSP_PULSE_CYCLES - 1); // RULE12
      o.pulses = (s.cfg.led.pulses == 8'h00) ? 8'h01 : s.cfg.led.pulses; // RULE11
    end else if (st == alsp_pkg::ST_WAIT) begin
      o.steps = `ALSP_STEPS_FULL - {1'b0, s.cfg.tm.wait_setting}; // RULE13
      o.mult = s.cfg.tm.wait_long ? `ALSP_LONG_WAIT_MULT : 4'h1;
    end
    return o;
  endfunction : go

  logic rise;
  logic fire;
  logic [4:0] pa;
  logic [4:0] pp;
  logic [15:0] prox_val;
  logic [7:0] a;
  logic [31:0] m;
  alsp_pkg::alsp_status_s clr;

  always_comb begin
    n = r;
    fire = 1'b0;
    pa = 5'h00;
    pp = 5'h00;
    prox_val = 16'h0000;
    m = 32'h0000_0000;
    clr = '0;
    a = 8'h00;

    // Link signals: stage 0 feeds only stage 1
    n.clk_s = {r.clk_s[1:0], sense_clk};
    n.wb_s = {r.wb_s[0], wideband_channel};
    n.ir_s = {r.ir_s[0], infrared_channel};
    n.sat_s = {r.sat_s[0], prox_saturated};
    rise = r.clk_s[1] && !r.clk_s[2];

    // Register write; AXI4-Lite address and data phases are accepted independently and land here
    if (s_axi_awvalid && r.awready) begin // RULE17
      n.aw_ok = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      n.w_ok = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_ok && n.w_ok && !r.bvalid) begin
      a = {n.awaddr[7:2], 2'b00};
      n.bvalid = 1'b1;
      n.bresp = `ALSP_RESP_OKAY;
      n.aw_ok = 1'b0;
      n.w_ok = 1'b0;
      if (a == `ALSP_OFF_ENABLE) begin
        n.cfg.en = alsp_pkg::alsp_enable_s'(merge(32'(r.cfg.en), n.wdata, n.wstrb));
        n.cfg.en.rsv = '0;
      end else if (a == `ALSP_OFF_TIME) begin
        n.cfg.tm = alsp_pkg::alsp_time_s'(merge(32'(r.cfg.tm), n.wdata, n.wstrb));
        n.cfg.tm.rsv = '0;
      end else if (a == `ALSP_OFF_ALS_THR) begin
        n.cfg.als_thr = alsp_pkg::alsp_thr_s'(merge(32'(r.cfg.als_thr), n.wdata, n.wstrb));
      end else if (a == `ALSP_OFF_PROX_THR) begin
        n.cfg.prox_thr = alsp_pkg::alsp_thr_s'(merge(32'(r.cfg.prox_thr), n.wdata, n.wstrb));
      end else if (a == `ALSP_OFF_PERS) begin
        n.cfg.pers = alsp_pkg::alsp_pers_s'(merge(32'(r.cfg.pers), n.wdata, n.wstrb));
        n.cfg.pers.rsv = '0;
      end else if (a == `ALSP_OFF_LED) begin
        n.cfg.led = alsp_pkg::alsp_led_s'(merge(32'(r.cfg.led), n.wdata, n.wstrb));
        n.cfg.led.rsv = '0;
      end else if (a == `ALSP_OFF_STATUS) begin
        // Write one to clear; only the host releases a raised interrupt
        m = merge(32'h0000_0000, n.wdata, n.wstrb);
        clr = alsp_pkg::alsp_status_s'(m);
        n.st.als_int = r.st.als_int && !clr.als_int; // RULE3
        n.st.prox_int = r.st.prox_int && !clr.prox_int; // RULE3
        n.st.prox_sat = r.st.prox_sat && !clr.prox_sat;
      end else if (a == `ALSP_OFF_DATA || a == `ALSP_OFF_PDATA) begin
        n.bresp = `ALSP_RESP_OKAY;
      end else begin
        n.bresp = `ALSP_RESP_DECERR;
      end
    end
    n.awready = !n.aw_ok && !n.bvalid;
    n.wready = !n.w_ok && !n.bvalid;

    // Register read; data is a snapshot taken at address acceptance
    if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end
    if (s_axi_arvalid && r.arready) begin
      a = {s_axi_araddr[7:2], 2'b00};
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = `ALSP_RESP_OKAY;
      if (a == `ALSP_OFF_ENABLE) begin
        n.rdata = 32'(r.cfg.en);
      end else if (a == `ALSP_OFF_TIME) begin
        n.rdata = 32'(r.cfg.tm);
      end else if (a == `ALSP_OFF_ALS_THR) begin
        n.rdata = 32'(r.cfg.als_thr);
      end else if (a == `ALSP_OFF_PROX_THR) begin
        n.rdata = 32'(r.cfg.prox_thr);
      end else if (a == `ALSP_OFF_PERS) begin
        n.rdata = 32'(r.cfg.pers);
      end else if (a == `ALSP_OFF_LED) begin
        n.rdata = 32'(r.cfg.led);
      end else if (a == `ALSP_OFF_STATUS) begin
        n.rdata = 32'(r.st);
      end else if (a == `ALSP_OFF_DATA) begin
        n.rdata = 32'(r.data);
      end else if (a == `ALSP_OFF_PDATA) begin
        n.rdata = {16'h0000, r.prox_data};
      end else begin
        n.rdata = 32'h0000_0000;
        n.rresp = `ALSP_RESP_DECERR;
      end
    end

    // Hardware sets come after the host clear so a same-cycle event survives
    if (r.sat_s[1]) begin
      n.st.prox_sat = 1'b1; // RULE15
    end

    case (r.state)
      alsp_pkg::ST_IDLE: begin
        if (r.cfg.en.power_on) begin // RULE21
          if (r.cfg.en.prox_en) begin
            n = go(n, alsp_pkg::ST_PROX);
          end else if (r.cfg.en.als_en) begin
            n = go(n, alsp_pkg::ST_ALS);
          end else if (r.cfg.en.wait_en) begin
            n = go(n, alsp_pkg::ST_WAIT);
          end
        end
      end
      alsp_pkg::ST_PROX: begin
        if (rise && r.ir_s[1] && r.led_oe && r.prox_acc != `ALSP_COUNT_MAX) begin
          n.prox_acc = r.prox_acc + 16'h0001;
        end
        if (r.timer != 24'h000000) begin
          n.timer = r.timer - 24'h000001;
        end else if (r.pulses != 8'h01) begin
          n.pulses = r.pulses - 8'h01; // RULE11
          n.timer = 24'(`ALSP_PULSE_CYCLES - 1); // RULE12
        end else begin
          prox_val = (n.prox_acc > {8'h00, r.cfg.led.prox_offset})
                     ? n.prox_acc - {8'h00, r.cfg.led.prox_offset} : 16'h0000; // RULE16
          n.prox_data = prox_val; // RULE2
          n.st.prox_valid = 1'b1;
          pp = pers_step(outside(prox_val, r.cfg.prox_thr), r.prox_pers_cnt,
                         r.cfg.pers.prox); // RULE6
          n.prox_pers_cnt = pp[3:0];
          if (pp[4]) begin
            n.st.prox_int = 1'b1; // RULE3
            fire = 1'b1;
          end
          if (r.cfg.en.als_en) begin
            n = go(n, alsp_pkg::ST_ALS); // RULE21
          end else begin
            n = go(n, r.cfg.en.wait_en ? alsp_pkg::ST_WAIT : alsp_pkg::ST_IDLE);
          end
        end
      end
      alsp_pkg::ST_ALS: begin
        if (rise && r.wb_s[1] && r.wb_step != `ALSP_STEP_CAP) begin
          n.wb_step = r.wb_step + 11'h001; // RULE1 RULE19
        end
        if (rise && r.ir_s[1] && r.ir_step != `ALSP_STEP_CAP) begin
          n.ir_step = r.ir_step + 11'h001; // RULE1 RULE19
        end
        if (r.timer != 24'h000000) begin
          n.timer = r.timer - 24'h000001;
        end else begin
          n.wb_acc = sat_add(r.wb_acc, n.wb_step);
          n.ir_acc = sat_add(r.ir_acc, n.ir_step);
          n.wb_step = 11'h000;
          n.ir_step = 11'h000;
          n.timer = 24'(STEP_CYCLES - 1);
          n.steps = r.steps - 9'h001; // RULE18
          if (r.steps == 9'h001) begin
            n.data.wideband_channel = n.wb_acc; // RULE2
            n.data.infrared_channel = n.ir_acc; // RULE2
            n.st.als_valid = 1'b1;
            pa = pers_step(outside(n.wb_acc, r.cfg.als_thr), r.als_pers_cnt,
                           r.cfg.pers.ambient_light_path); // RULE6
            n.als_pers_cnt = pa[3:0];
            if (pa[4]) begin
              n.st.als_int = 1'b1; // RULE3
              fire = 1'b1;
            end
            n = go(n, r.cfg.en.wait_en ? alsp_pkg::ST_WAIT : alsp_pkg::ST_IDLE); // RULE21
          end
        end
      end
      alsp_pkg::ST_WAIT: begin
        if (r.timer != 24'h000000) begin
          n.timer = r.timer - 24'h000001;
        end else if (r.steps != 9'h001) begin
          n.steps = r.steps - 9'h001; // RULE13
          n.timer = 24'(STEP_CYCLES - 1);
        end else if (r.mult != 4'h1) begin
          n.mult = r.mult - 4'h1; // RULE13
          n.steps = `ALSP_STEPS_FULL - {1'b0, r.cfg.tm.wait_setting};
          n.timer = 24'(STEP_CYCLES - 1);
        end else begin
          n = go(n, alsp_pkg::ST_IDLE); // RULE21
        end
      end
      alsp_pkg::ST_SLEEP: begin
        if (!n.st.als_int && !n.st.prox_int) begin
          n = go(n, alsp_pkg::ST_IDLE); // RULE14
        end
      end
      default: begin
        n = go(n, alsp_pkg::ST_IDLE);
      end
    endcase

    if (fire && r.cfg.en.sleep_after_int) begin
      n = go(n, alsp_pkg::ST_SLEEP); // RULE14
    end
    if (!n.cfg.en.power_on) begin
      n = go(n, alsp_pkg::ST_IDLE);
    end

    n.int_oe = (n.st.als_int && n.cfg.en.als_int_en)
               || (n.st.prox_int && n.cfg.en.prox_int_en); // RULE7 RULE8
    n.led_oe = (n.state == alsp_pkg::ST_PROX)
               && (n.timer >= 24'(`ALSP_LED_ON_CYCLES)); // RULE12
    n.led_level = n.cfg.led.led_sink_drive; // RULE9
    n.led_div = n.cfg.led.led_power_divide; // RULE10
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.state <= alsp_pkg::ST_IDLE;
      r.cfg.tm <= alsp_pkg::alsp_time_s'(`ALSP_TIME_RST);
      r.cfg.als_thr <= alsp_pkg::alsp_thr_s'(`ALSP_THR_RST);
      r.cfg.prox_thr <= alsp_pkg::alsp_thr_s'(`ALSP_THR_RST);
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  // Open-drain pins only ever pull low
  assign int_n_o = 1'b0;
  assign int_n_oe = r.int_oe;
  assign led_sink_o = 1'b0;
  assign led_sink_oe = r.led_oe;
  assign led_sink_drive = r.led_level;
  assign led_power_divide = r.led_div;

endmodule : alsp_core

// ==== alsp_core_monitor.sv ====
`timescale 1ns/1ns
`include "alsp_defines.svh"

module alsp_core_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic int_n_o,
  input wire logic int_n_oe,
  input wire logic led_sink_o,
  input wire logic led_sink_oe
);
  logic [11:0] on_cnt_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Length of the current LED sink pulse, zero while the sink is off
  always_ff @(posedge aclk) begin
    if (!aresetn || !led_sink_oe) begin
      on_cnt_r <= 12'h000;
    end else begin
      on_cnt_r <= on_cnt_r + 12'h001;
    end
  end

  rst_quiet_a: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !int_n_oe && !led_sink_oe)
    else $error("outputs active after reset");
  pin_drain_a: assert property (int_n_o == 1'b0 && led_sink_o == 1'b0)
    else $error("open drain pin driven high");
  b_stand_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response withdrawn early");
  r_stand_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data withdrawn early");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write not answered next cycle");
  int_hold_a: assert property (int_n_oe && !(s_axi_awvalid && s_axi_awready) &&
    !(s_axi_wvalid && s_axi_wready) |=> int_n_oe)
    else $error("interrupt dropped without host write");
  led_width_a: assert property ($fell(led_sink_oe) |->
    on_cnt_r == `ALSP_LED_ON_CYCLES)
    else $error("LED pulse length wrong");
endmodule : alsp_core_monitor

bind alsp_core alsp_core_monitor mon_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .int_n_o, .int_n_oe,
  .led_sink_o, .led_sink_oe);

// ==== alsp_front_model.sv ====
`timescale 1ns/1ns

module alsp_front_model (
  input wire logic run,
  input wire logic wb_on,
  input wire logic ir_on,
  input wire logic sat_on,
  output logic sense_clk,
  output logic wideband_channel,
  output logic infrared_channel,
  output logic prox_saturated
);
  initial begin
    sense_clk = 1'b0;
    wideband_channel = 1'b0;
    infrared_channel = 1'b0;
  end
  // Clock rests low between frames so the core sees no stray edges
  always #32 sense_clk = run ? ~sense_clk : 1'b0;
  // Levels move on the falling edge, clear of the sampling edge
  always @(negedge sense_clk) begin
    wideband_channel <= wb_on;
    infrared_channel <= ir_on;
  end
  assign prox_saturated = sat_on;
endmodule : alsp_front_model

// ==== alsp_core_test.sv ====
`timescale 1ns/1ns
`include "alsp_defines.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end

module alsp_core_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, int_n_o, int_n_oe, led_sink_o, led_sink_oe, led_power_divide;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, led_sink_drive, rsp;
  logic run, wb_on, ir_on, sat_on, sense_clk;
  logic wideband_channel, infrared_channel, prox_saturated;
  int error_cnt = 0;
  int check_count = 0;

  alsp_core #(.STEP_CYCLES(50)) dut_u (.*);
  alsp_front_model fe_u (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    `CHK("bvalid", 1'b1, s_axi_bvalid)
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    `CHK("rvalid", 1'b1, s_axi_rvalid)
  endtask : rd

  task automatic settle;
    repeat (4) @(posedge aclk);
  endtask : settle

  task automatic wait_int(input int lim);
    int n;
    n = 0;
    while (int_n_oe !== 1'b1 && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_int

  // Polls by bus reads, as firmware would, so the bus stays busy meanwhile
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      rd(`ALSP_OFF_STATUS);
      n++;
    end while (rd_d[b] !== 1'b1 && n < 3000);
  endtask : poll

  task automatic t_reset;
    rd(`ALSP_OFF_TIME);
    `CHK("time", `ALSP_TIME_RST, rd_d)
    rd(`ALSP_OFF_ALS_THR);
    `CHK("thr", `ALSP_THR_RST, rd_d)
    rd(`ALSP_OFF_ENABLE);
    `CHK("enable", 32'h00000000, rd_d)
    rd(8'h40);
    `CHK("rresp", `ALSP_RESP_DECERR, rsp)
    wr(8'h40, 32'hffffffff);
    `CHK("bresp", `ALSP_RESP_DECERR, rsp)
    $display("t_reset done");
  endtask : t_reset

  task automatic t_led;
    logic [31:0] v;
    for (int i = 0; i < 4; i++) begin
      v = {21'h000000, i[0], i[1:0], 8'h01};
      wr(`ALSP_OFF_LED, v);
      settle;
      `CHK("drive", i[1:0], led_sink_drive)
      `CHK("divide", i[0], led_power_divide)
      rd(`ALSP_OFF_LED);
      `CHK("led", v, rd_d)
    end
    $display("t_led done");
  endtask : t_led

  task automatic t_light;
    wb_on <= 1'b1;
    run <= 1'b1;
    wr(`ALSP_OFF_ENABLE, 32'h00000013);
    poll(0);
    rd(`ALSP_OFF_DATA);
    `CHK("ir", 16'h0000, rd_d[31:16])
    `CHK("wb", 1'b1, rd_d[15:0] != 16'h0000)
    `CHK("int", 1'b0, int_n_oe)
    wr(`ALSP_OFF_ALS_THR, 32'hffffffff);
    wait_int(2000);
    `CHK("int", 1'b1, int_n_oe)
    wr(`ALSP_OFF_ENABLE, 32'h00000003);
    settle;
    `CHK("int", 1'b0, int_n_oe)
    wr(`ALSP_OFF_ENABLE, 32'h00000010);
    settle;
    `CHK("int", 1'b1, int_n_oe)
    run <= 1'b0;
    wr(`ALSP_OFF_STATUS, 32'h00000004);
    settle;
    `CHK("int", 1'b0, int_n_oe)
    rd(`ALSP_OFF_STATUS);
    `CHK("flag", 1'b0, rd_d[2])
    wr(`ALSP_OFF_ALS_THR, `ALSP_THR_RST);
    wb_on <= 1'b0;
    $display("t_light done");
  endtask : t_light

  task automatic t_prox;
    ir_on <= 1'b1;
    run <= 1'b1;
    wr(`ALSP_OFF_LED, 32'h0007f901);
    wr(`ALSP_OFF_PROX_THR, 32'hffff0001);
    wr(`ALSP_OFF_PERS, 32'h00000030);
    wr(`ALSP_OFF_ENABLE, 32'h00000025);
    poll(1);
    rd(`ALSP_OFF_PDATA);
    `CHK("pdata", 16'h0000, rd_d[15:0])
    rd(`ALSP_OFF_STATUS);
    `CHK("pflag", 1'b0, rd_d[3])
    `CHK("int", 1'b0, int_n_oe)
    wait_int(20000);
    `CHK("int", 1'b1, int_n_oe)
    `CHK("drive", 2'h1, led_sink_drive)
    sat_on <= 1'b1;
    settle;
    rd(`ALSP_OFF_STATUS);
    `CHK("sat", 1'b1, rd_d[4])
    sat_on <= 1'b0;
    run <= 1'b0;
    // Power off only between LED pulses so no pulse is cut short
    wait (led_sink_oe === 1'b1);
    wait (led_sink_oe === 1'b0);
    wr(`ALSP_OFF_ENABLE, 32'h00000000);
    settle;
    wr(`ALSP_OFF_STATUS, 32'h0000001c);
    settle;
    `CHK("int", 1'b0, int_n_oe)
    rd(`ALSP_OFF_STATUS);
    `CHK("flags", 3'h0, rd_d[4:2])
    $display("t_prox done");
  endtask : t_prox

  task automatic t_sleep;
    int k;
    wr(`ALSP_OFF_PERS, 32'h00000000);
    wr(`ALSP_OFF_ENABLE, 32'h00000065);
    wait_int(20000);
    `CHK("int", 1'b1, int_n_oe)
    k = 0;
    repeat (5000) begin
      @(posedge aclk);
      if (led_sink_oe !== 1'b0) k++;
    end
    `CHK("sleep", 0, k)
    wr(`ALSP_OFF_STATUS, 32'h00000008);
    repeat (8) @(posedge aclk);
    `CHK("wake", 1'b1, led_sink_oe)
    wait (led_sink_oe === 1'b0);
    wr(`ALSP_OFF_ENABLE, 32'h00000000);
    wr(`ALSP_OFF_STATUS, 32'h0000001c);
    settle;
    `CHK("int", 1'b0, int_n_oe)
    $display("t_sleep done");
  endtask : t_sleep

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    aresetn <= 1'b0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h00000000;
    s_axi_wstrb <= 4'hf;
    run <= 1'b0;
    wb_on <= 1'b0;
    ir_on <= 1'b0;
    sat_on <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_led;
    t_light;
    t_prox;
    t_sleep;
    give_verdict;
  end

  // Whole run needs well under 40000 cycles
  initial begin
    #400000;
    error_cnt++;
    $display("watchdog expired");
    give_verdict;
  end
endmodule : alsp_core_test
